//--- verilog/cfe_regs.svh
// constants of the fetch/execute timing core
`ifndef CFE_REGS_SVH
`define CFE_REGS_SVH
`define CFE_PHASES        4
`define CFE_OSC_MHZ       40
`define CFE_REF_OSC_MHZ   10
`define CFE_REF_INSTR_NS  400
`define CFE_INSTR_NS      (`CFE_PHASES * 1000 / `CFE_OSC_MHZ)
`define CFE_NOP_WORD      14'h0000
`define CFE_ADDR_INDIRECT 7'h00
`define CFE_ADDR_PCL      7'h02
`define CFE_ADDR_STATUS   7'h03
`define CFE_ADDR_FSR      7'h04
`define CFE_STATUS_C      0
`define CFE_STATUS_HC     1
`define CFE_STATUS_Z      2
`define CFE_W_RESET       8'h00
`define CFE_STATUS_RESET  8'h00
`define CFE_FSR_RESET     8'h00
`endif

//--- verilog/cfe_pkg.sv
// types of the fetch/execute timing core
`default_nettype none
package cfe_pkg;
	typedef enum logic [1:0] {
		CFE_PH_ONE   = 2'b00,
		CFE_PH_TWO   = 2'b01,
		CFE_PH_THREE = 2'b10,
		CFE_PH_FOUR  = 2'b11
	} cfe_phase_e;
	typedef enum logic [2:0] {
		CFE_OSC_LOW_POWER_XTAL = 3'b000,
		CFE_OSC_STANDARD_XTAL  = 3'b001,
		CFE_OSC_FAST_XTAL      = 3'b010,
		CFE_OSC_INTERNAL_RC    = 3'b100,
		CFE_OSC_EXTERNAL_RC    = 3'b101
	} cfe_osc_e;
	typedef enum logic [3:0] {
		CFE_ALU_ADD   = 4'h0,
		CFE_ALU_SUB   = 4'h1,
		CFE_ALU_AND   = 4'h2,
		CFE_ALU_OR    = 4'h3,
		CFE_ALU_XOR   = 4'h4,
		CFE_ALU_PASSA = 4'h5,
		CFE_ALU_PASSB = 4'h6,
		CFE_ALU_INC   = 4'h7,
		CFE_ALU_DEC   = 4'h8,
		CFE_ALU_COM   = 4'h9,
		CFE_ALU_RL    = 4'ha,
		CFE_ALU_RR    = 4'hb,
		CFE_ALU_CLR   = 4'hc
	} cfe_alu_op_e;
	typedef struct packed {
		cfe_alu_op_e op;
		logic        lit;
		logic        to_file;
		logic        to_w;
		logic [2:0]  flags;
		logic        branch;
		logic        file_rd;
	} cfe_dec_s;
endpackage
`default_nettype wire

//--- verilog/cfe_alu_if.sv
// carrier between the core sequencer and its arithmetic unit
`timescale 1ns/100ps
`default_nettype none
interface cfe_alu_if;
	logic [7:0]          a;
	logic [7:0]          b;
	cfe_pkg::cfe_alu_op_e op;
	logic                c_in;
	logic [7:0]          y;
	logic                c;
	logic                hc;
	logic                z;
	modport core (output a, output b, output op, output c_in,
	              input y, input c, input hc, input z);
	modport alu  (input a, input b, input op, input c_in,
	              output y, output c, output hc, output z);
endinterface
`default_nettype wire

//--- verilog/cfe_alu.sv
// 8-bit arithmetic unit of the core
`timescale 1ns/100ps
`default_nettype none
module cfe_alu (
	// operands and result
	cfe_alu_if.alu bus
);
	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		bus.y = 8'h00;
		bus.c = bus.c_in;
		bus.hc = 1'b0;
		unique case (bus.op)
			cfe_pkg::CFE_ALU_ADD: begin
				sum = {1'b0, bus.b} + {1'b0, bus.a};
				nib = {1'b0, bus.b[3:0]} + {1'b0, bus.a[3:0]};
				bus.y = sum[7:0];
				bus.c = sum[8];
				bus.hc = nib[4];
			end
			// carry is the inverted borrow: set when nothing was borrowed
			cfe_pkg::CFE_ALU_SUB: begin
				sum = {1'b0, bus.b} + {1'b0, ~bus.a} + 9'h001;
				nib = {1'b0, bus.b[3:0]} + {1'b0, ~bus.a[3:0]} + 5'h01;
				bus.y = sum[7:0];
				bus.c = sum[8];
				bus.hc = nib[4];
			end
			cfe_pkg::CFE_ALU_AND:   bus.y = bus.a & bus.b;
			cfe_pkg::CFE_ALU_OR:    bus.y = bus.a | bus.b;
			cfe_pkg::CFE_ALU_XOR:   bus.y = bus.a ^ bus.b;
			cfe_pkg::CFE_ALU_PASSA: bus.y = bus.a;
			cfe_pkg::CFE_ALU_PASSB: bus.y = bus.b;
			cfe_pkg::CFE_ALU_INC:   bus.y = bus.b + 8'h01;
			cfe_pkg::CFE_ALU_DEC:   bus.y = bus.b - 8'h01;
			cfe_pkg::CFE_ALU_COM:   bus.y = ~bus.b;
			cfe_pkg::CFE_ALU_RL: begin
				bus.y = {bus.b[6:0], bus.c_in};
				bus.c = bus.b[7];
			end
			cfe_pkg::CFE_ALU_RR: begin
				bus.y = {bus.c_in, bus.b[7:1]};
				bus.c = bus.b[0];
			end
			cfe_pkg::CFE_ALU_CLR:   bus.y = 8'h00;
			default:                bus.y = 8'h00;
		endcase
		bus.z = (bus.y == 8'h00);
	end
endmodule // cfe_alu
`default_nettype wire

//--- verilog/cfe_core.sv
// four-phase fetch/execute sequencer with two-stage pipeline
`timescale 1ns/100ps
`default_nettype none
`include "cfe_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module cfe_core #(
	parameter int PC_W = 13
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	// master clear and oscillator options
	input  wire logic              master_clear_n,
	input  wire logic              clear_pin_enable,
	input  wire cfe_pkg::cfe_osc_e osc_mode,
	input  wire logic              cycle_clock_enable,
	// phase clocks
	output logic                   phase_one,
	output logic                   phase_two,
	output logic                   phase_three,
	output logic                   phase_four,
	// program memory
	output logic [PC_W-1:0]        prog_addr,
	input  wire logic [13:0]       prog_data,
	// data memory
	output logic [6:0]             data_addr,
	output logic                   data_rd_en,
	input  wire logic [7:0]        data_rdata,
	output logic                   data_wr_en,
	output logic [7:0]             data_wdata,
	// core state
	output logic [PC_W-1:0]        prog_counter,
	output logic [13:0]            instruction_latch,
	output logic [7:0]             accumulator,
	output logic [7:0]             status,
	// oscillator pins
	output logic                   cycle_clock_out,
	output logic                   cycle_clock_out_oe,
	output logic                   osc_output_pin_xtal,
	output logic                   osc_input_pin_io
);
	localparam int INSTR_NS = `CFE_INSTR_NS;

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks
	generate
		if (PC_W < 12 || PC_W > 16) begin : g_bad_pc
			$error("PC_W must be between 12 and 16");
		end
		if (`CFE_REF_INSTR_NS != `CFE_PHASES * 1000 / `CFE_REF_OSC_MHZ
		    || INSTR_NS * `CFE_OSC_MHZ != `CFE_PHASES * 1000) begin : g_bad_time
			$error("instruction cycle must span four oscillator periods");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// decode
	function automatic cfe_pkg::cfe_dec_s decode(input logic [13:0] ir);
		cfe_pkg::cfe_dec_s d;
		d = '{op: cfe_pkg::CFE_ALU_PASSB, lit: 1'b0, to_file: 1'b0, to_w: 1'b0,
		      flags: 3'b000, branch: 1'b0, file_rd: 1'b0};
		unique case (ir[13:12])
			// file operations: destination bit picks file or accumulator
			2'b00: begin
				d.file_rd = 1'b1;
				d.to_file = ir[7];
				d.to_w = ~ir[7];
				d.flags = 3'b100;
				unique case (ir[11:8])
					4'h0: begin
						d.op = cfe_pkg::CFE_ALU_PASSA;
						d.to_w = 1'b0;
						d.flags = 3'b000;
						d.file_rd = ir[7];
						d.to_file = ir[7];
					end
					4'h1: d.op = cfe_pkg::CFE_ALU_CLR;
					4'h2: begin
						d.op = cfe_pkg::CFE_ALU_SUB;
						d.flags = 3'b111;
					end
					4'h3: d.op = cfe_pkg::CFE_ALU_DEC;
					4'h4: d.op = cfe_pkg::CFE_ALU_OR;
					4'h5: d.op = cfe_pkg::CFE_ALU_AND;
					4'h6: d.op = cfe_pkg::CFE_ALU_XOR;
					4'h7: begin
						d.op = cfe_pkg::CFE_ALU_ADD;
						d.flags = 3'b111;
					end
					4'h8: d.op = cfe_pkg::CFE_ALU_PASSB;
					4'h9: d.op = cfe_pkg::CFE_ALU_COM;
					4'ha: d.op = cfe_pkg::CFE_ALU_INC;
					4'hc: begin
						d.op = cfe_pkg::CFE_ALU_RR;
						d.flags = 3'b001;
					end
					4'hd: begin
						d.op = cfe_pkg::CFE_ALU_RL;
						d.flags = 3'b001;
					end
					// skip and swap forms are not carried: they still strobe a file read but write nothing
					default: begin
						d.to_file = 1'b0;
						d.to_w = 1'b0;
						d.flags = 3'b000;
					end
				endcase
			end
			2'b01: d.file_rd = 1'b0;
			2'b10: d.branch = 1'b1;
			// literal operations land in the accumulator, except forms 01xx and 1011 of bits 11:8
			2'b11: begin
				d.lit = 1'b1;
				d.to_w = 1'b1;
				d.flags = 3'b100;
				casez (ir[11:8])
					4'b00??: begin
						d.op = cfe_pkg::CFE_ALU_PASSB;
						d.flags = 3'b000;
					end
					4'b1000: d.op = cfe_pkg::CFE_ALU_OR;
					4'b1001: d.op = cfe_pkg::CFE_ALU_AND;
					4'b1010: d.op = cfe_pkg::CFE_ALU_XOR;
					4'b110?: begin
						d.op = cfe_pkg::CFE_ALU_SUB;
						d.flags = 3'b111;
					end
					4'b111?: begin
						d.op = cfe_pkg::CFE_ALU_ADD;
						d.flags = 3'b111;
					end
					default: begin
						d.to_w = 1'b0;
						d.flags = 3'b000;
					end
				endcase
			end
		endcase
		return d;
	endfunction

	function automatic logic is_internal(input logic [6:0] a);
		return a == `CFE_ADDR_PCL || a == `CFE_ADDR_STATUS || a == `CFE_ADDR_FSR;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state
	cfe_pkg::cfe_phase_e ph_q;
	cfe_pkg::cfe_phase_e ph_d;
	logic [3:0]          phase_oh_q;
	logic [PC_W-1:0]     pc_q;
	logic [PC_W-1:0]     prog_addr_q;
	logic [13:0]         fetch_ir_q;
	logic [13:0]         exec_ir_q;
	logic                flush_q;
	logic [6:0]          ea_q;
	logic                rd_en_q;
	logic                wr_en_q;
	logic [7:0]          wdata_q;
	logic [7:0]          opnd_q;
	logic [7:0]          res_q;
	logic [2:0]          flag_val_q;
	logic [7:0]          w_q;
	logic [7:0]          status_q;
	logic [7:0]          fsr_q;
	logic                clk_out_q;
	logic                clk_oe_q;
	logic                xtal_q;
	logic                in_io_q;
	logic                clear_now;
	logic [13:0]         ir_nx;
	logic [6:0]          ea_nx;
	cfe_pkg::cfe_dec_s   dec_nx;
	cfe_pkg::cfe_dec_s   dec_x;
	logic                take_branch;
	logic [PC_W-1:0]     target;
	logic                rc_mode;

	cfe_alu_if alu_bus ();

	cfe_alu u_alu (
		.bus (alu_bus)
	);

	// synchronous so a glitch on the shared pin cannot tear a phase apart
	assign clear_now = clear_pin_enable & ~master_clear_n;

	// the slot after a branch is replaced so nothing it encodes takes effect
	assign ir_nx = flush_q ? `CFE_NOP_WORD : fetch_ir_q;
	assign dec_nx = decode(ir_nx);
	assign dec_x = decode(exec_ir_q);
	assign ea_nx = (ir_nx[6:0] == `CFE_ADDR_INDIRECT) ? fsr_q[6:0] : ir_nx[6:0];

	// accumulator is only ever an operand, never a data address
	assign alu_bus.a = w_q;
	assign alu_bus.b = opnd_q;
	assign alu_bus.op = dec_x.op;
	assign alu_bus.c_in = status_q[`CFE_STATUS_C];

	assign take_branch = dec_x.branch | (dec_x.to_file & ea_q == `CFE_ADDR_PCL);
	assign target = dec_x.branch ? {pc_q[PC_W-1:11], exec_ir_q[10:0]}
	                             : {pc_q[PC_W-1:8], res_q};
	assign rc_mode = osc_mode == cfe_pkg::CFE_OSC_EXTERNAL_RC
	              || osc_mode == cfe_pkg::CFE_OSC_INTERNAL_RC;

	////////////////////////////////////////////////////////////////////////////
	// phase generator
	always_comb begin
		unique case (ph_q)
			cfe_pkg::CFE_PH_ONE:   ph_d = cfe_pkg::CFE_PH_TWO;
			cfe_pkg::CFE_PH_TWO:   ph_d = cfe_pkg::CFE_PH_THREE;
			cfe_pkg::CFE_PH_THREE: ph_d = cfe_pkg::CFE_PH_FOUR;
			cfe_pkg::CFE_PH_FOUR:  ph_d = cfe_pkg::CFE_PH_ONE;
		endcase
		if (clear_now) begin
			ph_d = cfe_pkg::CFE_PH_ONE;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ph_q <= cfe_pkg::CFE_PH_ONE;
			phase_oh_q <= 4'h1;
		end else begin
			ph_q <= ph_d;
			phase_oh_q <= 4'h1 << ph_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fetch and program counter
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q <= '0;
			prog_addr_q <= '0;
			fetch_ir_q <= `CFE_NOP_WORD;
			exec_ir_q <= `CFE_NOP_WORD;
			flush_q <= 1'b0;
		end else if (clear_now) begin
			pc_q <= '0;
			prog_addr_q <= '0;
			fetch_ir_q <= `CFE_NOP_WORD;
			exec_ir_q <= `CFE_NOP_WORD;
			flush_q <= 1'b0;
		end else begin
			unique case (ph_q)
				cfe_pkg::CFE_PH_ONE: begin
					prog_addr_q <= pc_q;
					pc_q <= pc_q + 1'b1;
					exec_ir_q <= ir_nx;
					flush_q <= 1'b0;
				end
				cfe_pkg::CFE_PH_FOUR: begin
					fetch_ir_q <= prog_data;
					if (take_branch) begin
						pc_q <= target;
						flush_q <= 1'b1;
					end
				end
				default: begin
					flush_q <= flush_q;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data memory access
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ea_q <= 7'h00;
			rd_en_q <= 1'b0;
			wr_en_q <= 1'b0;
			wdata_q <= 8'h00;
			opnd_q <= 8'h00;
		end else if (clear_now) begin
			rd_en_q <= 1'b0;
			wr_en_q <= 1'b0;
		end else begin
			unique case (ph_q)
				cfe_pkg::CFE_PH_ONE: begin
					ea_q <= ea_nx;
					rd_en_q <= dec_nx.file_rd & ~is_internal(ea_nx);
				end
				cfe_pkg::CFE_PH_TWO: begin
					rd_en_q <= 1'b0;
					if (dec_x.lit) begin
						opnd_q <= exec_ir_q[7:0];
					end else if (ea_q == `CFE_ADDR_PCL) begin
						opnd_q <= pc_q[7:0];
					end else if (ea_q == `CFE_ADDR_STATUS) begin
						opnd_q <= status_q;
					end else if (ea_q == `CFE_ADDR_FSR) begin
						opnd_q <= fsr_q;
					end else begin
						opnd_q <= data_rdata;
					end
				end
				cfe_pkg::CFE_PH_THREE: begin
					wr_en_q <= dec_x.to_file & ~is_internal(ea_q);
					wdata_q <= alu_bus.y;
				end
				cfe_pkg::CFE_PH_FOUR: begin
					wr_en_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// execute and write back
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			res_q <= 8'h00;
			flag_val_q <= 3'b000;
			w_q <= `CFE_W_RESET;
			status_q <= `CFE_STATUS_RESET;
			fsr_q <= `CFE_FSR_RESET;
		end else if (clear_now) begin
			w_q <= `CFE_W_RESET;
			status_q <= `CFE_STATUS_RESET;
			fsr_q <= `CFE_FSR_RESET;
		end else if (ph_q == cfe_pkg::CFE_PH_THREE) begin
			res_q <= alu_bus.y;
			flag_val_q <= {alu_bus.z, alu_bus.hc, alu_bus.c};
		end else if (ph_q == cfe_pkg::CFE_PH_FOUR) begin
			if (dec_x.to_w) begin
				w_q <= res_q;
			end
			if (dec_x.to_file && ea_q == `CFE_ADDR_FSR) begin
				fsr_q <= res_q;
			end
			// flags of the operation win over a plain store to the same bits
			for (int i = 0; i < 8; i++) begin
				if (i < 3 && dec_x.flags[i]) begin
					status_q[i] <= flag_val_q[i];
				end else if (dec_x.to_file && ea_q == `CFE_ADDR_STATUS) begin
					status_q[i] <= res_q[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// oscillator pin options
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_out_q <= 1'b0;
			clk_oe_q <= 1'b0;
			xtal_q <= 1'b0;
			in_io_q <= 1'b0;
		end else begin
			// high in phases one and two, one period per instruction cycle
			clk_oe_q <= rc_mode & cycle_clock_enable;
			clk_out_q <= rc_mode & cycle_clock_enable
			           & (ph_d == cfe_pkg::CFE_PH_ONE || ph_d == cfe_pkg::CFE_PH_TWO);
			xtal_q <= ~rc_mode;
			in_io_q <= osc_mode == cfe_pkg::CFE_OSC_INTERNAL_RC;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign phase_one = phase_oh_q[0];
	assign phase_two = phase_oh_q[1];
	assign phase_three = phase_oh_q[2];
	assign phase_four = phase_oh_q[3];
	assign prog_addr = prog_addr_q;
	assign data_addr = ea_q;
	assign data_rd_en = rd_en_q;
	assign data_wr_en = wr_en_q;
	assign data_wdata = wdata_q;
	assign prog_counter = pc_q;
	assign instruction_latch = fetch_ir_q;
	assign accumulator = w_q;
	assign status = status_q;
	assign cycle_clock_out = clk_out_q;
	assign cycle_clock_out_oe = clk_oe_q;
	assign osc_output_pin_xtal = xtal_q;
	assign osc_input_pin_io = in_io_q;
endmodule // cfe_core
`default_nettype wire

//--- dv/cfe_core_asserts.sv
// port checks of the fetch/execute core
`timescale 1ns/100ps
`default_nettype none
module cfe_core_asserts #(
	parameter int PC_W = 13
) (
	// clock and resets
	input wire logic            core_clk,
	input wire logic            reset_n,
	input wire logic            master_clear_n,
	input wire logic            clear_pin_enable,
	// phases
	input wire logic            phase_one,
	input wire logic            phase_two,
	input wire logic            phase_three,
	input wire logic            phase_four,
	// buses and state
	input wire logic [PC_W-1:0] prog_addr,
	input wire logic [13:0]     prog_data,
	input wire logic [6:0]      data_addr,
	input wire logic            data_rd_en,
	input wire logic            data_wr_en,
	input wire logic [PC_W-1:0] prog_counter,
	input wire logic [13:0]     instruction_latch,
	input wire logic            cycle_clock_out
);
	logic run_q;
	// lags reset and master clear by one edge so the restart edge is never judged
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			run_q <= 1'b0;
		else
			run_q <= !(clear_pin_enable && !master_clear_n);
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!run_q);
	////////////////////////////////////////
	phase_hot_a:
		assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
		else $error("phase outputs not one-hot");
	phase_ring_a:
		assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
		else $error("phase order broken");
	pc_step_a:
		assert property (phase_one |=> prog_addr == $past(prog_counter)
			&& prog_counter == PC_W'($past(prog_counter) + 1'b1))
		else $error("counter step or fetch address wrong");
	latch_hold_a:
		assert property (!phase_four |=> $stable(instruction_latch))
		else $error("latch changed outside phase four");
	latch_take_a:
		assert property (phase_four |=> instruction_latch == $past(prog_data))
		else $error("fetched word not latched");
	addr_hold_a:
		assert property (!phase_one |=> $stable(prog_addr) && $stable(data_addr))
		else $error("address moved mid cycle");
	rd_phase_a:
		assert property (data_rd_en |-> phase_two)
		else $error("operand read outside phase two");
	wr_phase_a:
		assert property (data_wr_en |-> phase_four)
		else $error("write outside phase four");
	sfr_local_a:
		assert property ((data_rd_en || data_wr_en) |-> !(data_addr inside {7'h02, 7'h03, 7'h04}))
		else $error("strobe on internal register");
	cycle_clk_phase_a:
		assert property (cycle_clock_out |-> phase_one || phase_two)
		else $error("cycle clock high in late phases");
	wr_seen_c: cover property (data_wr_en);
	rd_seen_c: cover property (data_rd_en);
	cycle_clk_seen_c: cover property (cycle_clock_out);
endmodule // cfe_core_asserts

bind cfe_core cfe_core_asserts #(.PC_W(PC_W)) cfe_core_asserts_i (
	.core_clk, .reset_n, .master_clear_n, .clear_pin_enable, .phase_one, .phase_two,
	.phase_three, .phase_four, .prog_addr, .prog_data, .data_addr, .data_rd_en,
	.data_wr_en, .prog_counter, .instruction_latch, .cycle_clock_out
);
`default_nettype wire

//--- dv/cfe_mem_model.sv
// program memory and register file beside the core
`timescale 1ns/100ps
`default_nettype none
module cfe_mem_model #(
	parameter int PC_W = 13
) (
	// clock
	input wire logic            core_clk,
	// program bus
	input wire logic [PC_W-1:0] prog_addr,
	output logic [13:0]         prog_data,
	// data bus
	input wire logic [6:0]      data_addr,
	input wire logic            data_rd_en,
	output logic [7:0]          data_rdata,
	input wire logic            data_wr_en,
	input wire logic [7:0]      data_wdata
);
	logic [13:0] prog [0:(1<<PC_W)-1];
	logic [7:0]  file [0:127];
	logic [7:0]  last_q = 8'h5a;
	assign prog_data = prog[prog_addr];
	// unselected lines show the inverse of the last byte, never a held value
	assign data_rdata = data_rd_en ? file[data_addr] : ~last_q;
	always @(posedge core_clk) begin
		if (data_rd_en)
			last_q <= file[data_addr];
		if (data_wr_en)
			file[data_addr] <= data_wdata;
	end
endmodule // cfe_mem_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench of the fetch/execute core
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct {
		logic [6:0] a;
		logic [7:0] d;
		int         gap;
	} cfe_exp_s;
	localparam int PC_W = 12;
	logic              core_clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              master_clear_n = 1'b1;
	logic              clear_pin_enable = 1'b0;
	logic              cycle_clock_enable = 1'b0;
	cfe_pkg::cfe_osc_e osc_mode = cfe_pkg::CFE_OSC_STANDARD_XTAL;
	logic              phase_one, phase_two, phase_three, phase_four;
	logic              data_rd_en, data_wr_en, cycle_clock_out, cycle_clock_out_oe;
	logic              osc_output_pin_xtal, osc_input_pin_io;
	logic [PC_W-1:0]   prog_addr, prog_counter;
	logic [13:0]       prog_data, instruction_latch;
	logic [6:0]        data_addr;
	logic [7:0]        data_rdata, data_wdata, accumulator, status;
	int                n_errors = 0;
	int                n_checks = 0;
	int                cycles = 0;
	logic [31:0]       seed = 32'he7bf;
	cfe_exp_s          exp_q[$];
	cfe_exp_s          e;
	time               last_t = 0;
	cfe_pkg::cfe_osc_e modes [5] = '{cfe_pkg::CFE_OSC_LOW_POWER_XTAL,
		cfe_pkg::CFE_OSC_STANDARD_XTAL, cfe_pkg::CFE_OSC_FAST_XTAL,
		cfe_pkg::CFE_OSC_INTERNAL_RC, cfe_pkg::CFE_OSC_EXTERNAL_RC};

	cfe_core #(.PC_W(PC_W)) cfe_core_i (
		.core_clk, .reset_n, .master_clear_n, .clear_pin_enable, .osc_mode,
		.cycle_clock_enable,
		.phase_one, .phase_two, .phase_three, .phase_four, .prog_addr, .prog_data,
		.data_addr, .data_rd_en, .data_rdata, .data_wr_en, .data_wdata, .prog_counter,
		.instruction_latch, .accumulator, .status, .cycle_clock_out, .cycle_clock_out_oe,
		.osc_output_pin_xtal, .osc_input_pin_io
	);
	cfe_mem_model #(.PC_W(PC_W)) cfe_mem_model_i (
		.core_clk, .prog_addr, .prog_data, .data_addr, .data_rd_en, .data_rdata,
		.data_wr_en, .data_wdata
	);

	always #12.5 core_clk = ~core_clk;
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		n_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// k=0 plain reset with clear pin ignored, k=1 master clear, k=2 plain reset
	task automatic t_prog(input int k);
		logic [23:0] r;
		logic [7:0]  s1;
		logic [7:0]  s2;
		logic [13:0] w [11];
		seed = xs(seed);
		r = seed[23:0];
		s1 = r[7:0] + r[15:8];
		s2 = r[23:16] - s1;
		@(posedge core_clk);
		reset_n <= (k == 1);
		clear_pin_enable <= (k != 0);
		master_clear_n <= (k != 1);
		// word 7 sits in the flushed slot and word 8 is jumped over
		w = '{{6'h30, r[7:0]}, {6'h3e, r[15:8]}, 14'h00a0, {6'h3c, r[23:16]}, 14'h00a1,
			14'h06a0, 14'h2809, 14'h30ff, 14'h00a2, 14'h00a3, 14'h280a};
		for (int i = 0; i < 16; i++)
			cfe_mem_model_i.prog[i] = (i < 11) ? w[i] : 14'h0000;
		exp_q.push_back('{7'h20, s1, 0});
		exp_q.push_back('{7'h21, s2, 8});
		exp_q.push_back('{7'h20, s1 ^ s2, 4});
		exp_q.push_back('{7'h23, s2, 12});
		repeat (11) @(posedge core_clk);
		#1;
		if (k == 1) begin
			check(accumulator, 8'h00, "clear left accumulator");
			check(phase_one, 1'b1, "clear left phase");
		end
		@(posedge core_clk);
		reset_n <= 1'b1;
		master_clear_n <= 1'b1;
		for (int i = 0; i < 200 && exp_q.size() > 0; i++)
			@(posedge core_clk);
		check(exp_q.size(), 0, "writes missing");
		repeat (4) @(posedge core_clk);
		check(accumulator, s2, "accumulator");
		check(status[2:0], {(s1 ^ s2) == 8'h00, r[19:16] >= s1[3:0], r[23:16] >= s1},
			"flags");
	endtask

	task automatic t_osc();
		int  hi;
		logic rc;
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			osc_mode <= modes[i / 2];
			cycle_clock_enable <= i[0];
			rc = modes[i / 2] inside {cfe_pkg::CFE_OSC_INTERNAL_RC, cfe_pkg::CFE_OSC_EXTERNAL_RC};
			hi = 0;
			repeat (3) @(posedge core_clk);
			repeat (8) begin
				@(posedge core_clk);
				hi += cycle_clock_out;
			end
			check(hi, (rc && i[0]) ? 4 : 0, "cycle clock rate");
			check(cycle_clock_out_oe, rc && i[0], "cycle clock enable");
			check(osc_output_pin_xtal, !modes[i / 2][2], "crystal pin");
			check(osc_input_pin_io, i / 2 == 3, "input pin io");
		end
	endtask

	always @(posedge core_clk) begin
		if (data_wr_en === 1'b1) begin
			if (exp_q.size() == 0)
				check(1, 0, "unexpected write");
			else begin
				e = exp_q.pop_front();
				check(data_addr, e.a, "write address");
				check(data_wdata, e.d, "write data");
				if (e.gap > 0)
					check(32'($time - last_t), 32'(e.gap * 25), "spacing");
			end
			last_t = $time;
		end
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 1500) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		for (int k = 0; k < 3; k++) begin
			t_prog(k);
			$display("test program %0d done", k);
		end
		t_osc();
		$display("test oscillator options done");
		final_report();
	end
endmodule // testbench
`default_nettype wire
